// *** byte_alu_defs.vh ***
`ifndef BYTE_ALU_DEFS_VH
`define BYTE_ALU_DEFS_VH

`define ADDR_WIDTH        7
`define DATA_WIDTH        8
`define FILE_DEPTH        128
`define ACC_RESET         8'h00
`define FILE_RESET        8'h00

`define OP_WIDTH          3
`define OP_NONE           3'h0
`define OP_SUB_ACC_FILE   3'h1
`define OP_XOR_ACC_FILE   3'h2
`define OP_SWAP_NIBBLES   3'h3
`define OP_XOR_LIT_ACC    3'h4

`define DEST_ACC          1'b0
`define DEST_FILE         1'b1

`define STATUS_CARRY_BIT  0
`define STATUS_DC_BIT     1
`define STATUS_ZERO_BIT   2
`define STATUS_RESET      3'h0

`define APB_ADDR_WIDTH    12
`define REG_ACC           12'h000
`define REG_STATUS        12'h004
`define REG_COMMAND       12'h008
`define REG_FILE_ADDR     12'h00C
`define REG_FILE_DATA     12'h010

`endif

// *** byte_file_mem.v ***
`timescale 1ns/10ps
`default_nettype none
`include "byte_alu_defs.vh"

module byte_file_mem (
    input  wire                     i_clk,
    input  wire                     i_wr_en,
    input  wire [`ADDR_WIDTH-1:0]   i_wr_addr,
    input  wire [`DATA_WIDTH-1:0]   i_wr_data,
    input  wire [`ADDR_WIDTH-1:0]   i_rd_addr,
    output reg  [`DATA_WIDTH-1:0]   o_rd_data
);
    reg [`DATA_WIDTH-1:0] mem [0:`FILE_DEPTH-1];
    integer k;

    // No reset on the array; contents start cleared for simulation only
    initial begin
        for (k = 0; k < `FILE_DEPTH; k = k + 1) begin
            mem[k] = `FILE_RESET;
        end
    end

    always @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
    end
endmodule // byte_file_mem

`default_nettype wire

// *** byte_alu_sub_xor_swap.v ***
// Overview of operation
// - File minus accumulator; carry and digit carry are not-borrow of byte and nibble.
// - Accumulator XOR file byte; only zero flag changes.
// - Swap nibbles of file byte; no flag changes.
// - Accumulator XOR 8-bit literal into accumulator; only zero flag changes.
// - Destination bit 0 writes accumulator, 1 writes back the file byte; the literal XOR always writes the accumulator.
// - Seven-bit file address selects one of 128 bytes for file operations.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "byte_alu_defs.vh"

module byte_alu_sub_xor_swap (
    input  wire                         i_clk,
    input  wire                         i_reset,
    input  wire                         i_psel,
    input  wire                         i_penable,
    input  wire                         i_pwrite,
    input  wire [`APB_ADDR_WIDTH-1:0]   i_paddr,
    input  wire [31:0]                  i_pwdata,
    input  wire [3:0]                   i_pstrb,
    output wire                         o_pready,
    output reg  [31:0]                  o_prdata,
    output reg                          o_pslverr,
    output wire                         o_busy
);
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_FETCH = 5'h02;
    localparam [4:0] ST_EXEC  = 5'h04;
    localparam [4:0] ST_MRD   = 5'h08;
    localparam [4:0] ST_RESP  = 5'h10;

    reg [4:0]               state;
    reg [`DATA_WIDTH-1:0]   acc;
    reg [2:0]               status;
    reg [`OP_WIDTH-1:0]     op;
    reg                     dest;
    reg [`ADDR_WIDTH-1:0]   file_addr;
    reg [`DATA_WIDTH-1:0]   literal;
    reg [`ADDR_WIDTH-1:0]   peek_addr;

    reg                     mem_wr_en;
    reg [`ADDR_WIDTH-1:0]   mem_wr_addr;
    reg [`DATA_WIDTH-1:0]   mem_wr_data;
    wire [`DATA_WIDTH-1:0]  file_byte;
    wire [`ADDR_WIDTH-1:0]  mem_rd_addr;

    reg [`DATA_WIDTH-1:0]   next_result;
    reg [2:0]               next_status;
    reg [`DATA_WIDTH:0]     diff;
    reg [4:0]               ndiff;

    wire access   = i_psel && i_penable;
    wire is_write = access && i_pwrite;
    wire is_read  = access && !i_pwrite;
    wire setup    = i_psel && !i_penable;
    // Transfers that must wait for the memory or the datapath
    wire slow     = (is_read && i_paddr == `REG_FILE_DATA)
                    || (is_write && i_paddr == `REG_COMMAND);

    function is_zero;
        input [`DATA_WIDTH-1:0] value;
        begin
            is_zero = (value == `DATA_WIDTH'h00);
        end
    endfunction

    function mapped;
        input [`APB_ADDR_WIDTH-1:0] addr;
        begin
            if (addr == `REG_ACC) mapped = 1'b1;
            else if (addr == `REG_STATUS) mapped = 1'b1;
            else if (addr == `REG_COMMAND) mapped = 1'b1;
            else if (addr == `REG_FILE_ADDR) mapped = 1'b1;
            else if (addr == `REG_FILE_DATA) mapped = 1'b1;
            else mapped = 1'b0;
        end
    endfunction

    // Reserved op codes run the sequence but change nothing
    function valid_op;
        input [`OP_WIDTH-1:0] code;
        begin
            if (code == `OP_SUB_ACC_FILE) valid_op = 1'b1;
            else if (code == `OP_XOR_ACC_FILE) valid_op = 1'b1;
            else if (code == `OP_SWAP_NIBBLES) valid_op = 1'b1;
            else if (code == `OP_XOR_LIT_ACC) valid_op = 1'b1;
            else valid_op = 1'b0;
        end
    endfunction

    // Read data and error are loaded in the setup cycle, so most accesses
    // answer at once; file reads and commands wait for the memory or datapath
    assign o_pready    = (state == ST_RESP) || (access && (state == ST_IDLE) && !slow);
    assign o_busy      = (state == ST_FETCH) || (state == ST_EXEC);
    // Operations read their own operand; otherwise the peek address is read
    assign mem_rd_addr = ((state == ST_FETCH) || (state == ST_EXEC)) ? file_addr
                         : peek_addr;

    // Array has no reset; file bytes read as left by the last write
    byte_file_mem u_file (
        .i_clk     (i_clk),
        .i_wr_en   (mem_wr_en),
        .i_wr_addr (mem_wr_addr),
        .i_wr_data (mem_wr_data),
        .i_rd_addr (mem_rd_addr),
        .o_rd_data (file_byte)
    );

    always @* begin
        // Top bit of each widened difference is the borrow
        diff        = {1'b0, file_byte} - {1'b0, acc};
        ndiff       = {1'b0, file_byte[3:0]} - {1'b0, acc[3:0]};
        next_result = acc;
        next_status = status;
        case (op)
            `OP_SUB_ACC_FILE: begin
                next_result = diff[`DATA_WIDTH-1:0];
                next_status[`STATUS_CARRY_BIT] = ~diff[`DATA_WIDTH];
                next_status[`STATUS_DC_BIT]    = ~ndiff[4];
                next_status[`STATUS_ZERO_BIT]  = is_zero(diff[`DATA_WIDTH-1:0]);
            end
            `OP_XOR_ACC_FILE: begin
                next_result = acc ^ file_byte;
                next_status[`STATUS_ZERO_BIT] = is_zero(acc ^ file_byte);
            end
            `OP_SWAP_NIBBLES: begin
                next_result = {file_byte[3:0], file_byte[7:4]};
            end
            `OP_XOR_LIT_ACC: begin
                next_result = acc ^ literal;
                next_status[`STATUS_ZERO_BIT] = is_zero(acc ^ literal);
            end
            default: begin
                next_result = acc;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            state       <= ST_IDLE;
            acc         <= `ACC_RESET;
            status      <= `STATUS_RESET;
            op          <= `OP_NONE;
            dest        <= `DEST_ACC;
            file_addr   <= 7'h00;
            literal     <= 8'h00;
            peek_addr   <= 7'h00;
            mem_wr_en   <= 1'b0;
            mem_wr_addr <= 7'h00;
            mem_wr_data <= 8'h00;
            o_prdata    <= 32'h00000000;
            o_pslverr   <= 1'b0;
        end else begin
            mem_wr_en <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Pready is combinational, so the answer must already stand
                    // in the access cycle; it is prepared during setup
                    if (setup) begin
                        o_pslverr <= !mapped(i_paddr);
                    end
                    if (setup && !i_pwrite) begin
                        if (i_paddr == `REG_ACC) o_prdata <= {24'h000000, acc};
                        else if (i_paddr == `REG_STATUS) o_prdata <= {29'h0, status};
                        else if (i_paddr == `REG_COMMAND)
                            o_prdata <= {8'h00, literal, 1'b0, file_addr, 4'h0, dest, op};
                        else if (i_paddr == `REG_FILE_ADDR) o_prdata <= {25'h0, peek_addr};
                        else if (i_paddr != `REG_FILE_DATA) o_prdata <= 32'h00000000;
                    end
                    // Unmapped writes fall through with no effect
                    if (is_write && i_paddr == `REG_ACC) begin
                        if (i_pstrb[0]) acc <= i_pwdata[7:0];
                    end else if (is_write && i_paddr == `REG_STATUS) begin
                        if (i_pstrb[0]) status <= i_pwdata[2:0];
                    end else if (is_write && i_paddr == `REG_FILE_ADDR) begin
                        if (i_pstrb[0]) peek_addr <= i_pwdata[6:0];
                    end else if (is_write && i_paddr == `REG_FILE_DATA) begin
                        mem_wr_en   <= i_pstrb[0];
                        mem_wr_addr <= peek_addr;
                        mem_wr_data <= i_pwdata[7:0];
                    end else if (is_write && i_paddr == `REG_COMMAND) begin
                        op        <= i_pwdata[2:0];
                        dest      <= i_pwdata[3];
                        file_addr <= i_pwdata[14:8];
                        literal   <= i_pwdata[23:16];
                        state     <= ST_FETCH;
                    end else if (is_read && i_paddr == `REG_FILE_DATA) begin
                        state <= ST_MRD;
                    end
                end
                ST_FETCH: begin
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    status <= next_status;
                    if (valid_op(op)) begin
                        if (op == `OP_XOR_LIT_ACC || dest == `DEST_ACC) begin
                            acc <= next_result;
                        end else begin
                            mem_wr_en   <= 1'b1;
                            mem_wr_addr <= file_addr;
                            mem_wr_data <= next_result;
                        end
                    end
                    state <= ST_RESP;
                end
                ST_MRD: begin
                    // Memory output was loaded at the access edge from the peek address
                    o_prdata <= {24'h000000, file_byte};
                    state    <= ST_RESP;
                end
                ST_RESP: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // byte_alu_sub_xor_swap

`default_nettype wire

// *** alu_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "byte_alu_defs.vh"
module alu_chk (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic        o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire acc = i_psel && i_penable;
    wire mapped = i_paddr <= 12'h010 && i_paddr[1:0] == 2'h0;
    cmd_latency_a: assert property (acc && i_pwrite && i_paddr == `REG_COMMAND
        && !$past(i_penable) |-> !o_pready [*3] ##1 o_pready) else $error("command wait wrong");
    cmd_busy_a: assert property (acc && i_pwrite && i_paddr == `REG_COMMAND
        && !$past(i_penable) |-> ##1 o_busy [*2]) else $error("busy not shown");
    busy_ends_a: assert property ($rose(o_busy) |-> ##[1:3] !o_busy)
        else $error("busy stuck");
    fdata_wait_a: assert property (acc && !i_pwrite && i_paddr == `REG_FILE_DATA
        && !$past(i_penable) |-> !o_pready [*2] ##1 o_pready) else $error("file read wait wrong");
    fast_acc_a: assert property (acc && i_paddr == `REG_ACC |-> o_pready)
        else $error("acc access slow");
    err_map_a: assert property (acc && o_pready |-> o_pslverr == !mapped)
        else $error("slave error wrong");
    err_data_a: assert property (acc && o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("refused read not zero");
    cover property (o_busy);
    cover property (acc && o_pready && o_pslverr);
    cover property (acc && !i_pwrite && i_paddr == `REG_FILE_DATA && o_pready);
endmodule // alu_chk
bind byte_alu_sub_xor_swap alu_chk alu_chk_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_busy(o_busy));
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "byte_alu_defs.vh"
module tb;
    logic        i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0;
    logic [3:0]  i_pstrb = 4'hF;
    wire         o_pready, o_pslverr, o_busy;
    wire  [31:0] o_prdata;
    int          failures = 0, checks_done = 0;
    logic [32:0] expq[$];
    logic [7:0]  a, f, lit, r;
    logic [6:0]  adr;
    logic [2:0]  op, st;
    logic        d;
    always #2 i_clk = ~i_clk;
    byte_alu_sub_xor_swap byte_alu_sub_xor_swap_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata),
        .o_pslverr(o_pslverr), .o_busy(o_busy));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED err_and_prdata exp %h seen %h", exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        i_psel    <= 1'b1;
        i_pwrite  <= w;
        i_paddr   <= ad;
        i_pwdata  <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // No wait count assumed; only the watchdog ends a hung transfer
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    always @(posedge i_clk)
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
            check({o_pslverr, o_prdata}, expq.pop_front());
    initial begin
        #100000;
        failures++;
        finish_test;
    end
    initial begin
        a = 8'($urandom(32'hAC2AF762));
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        rd(12'h020, {1'b1, 32'h0});
        for (int i = 0; i < 60; i++) begin
            f   = 8'($urandom);
            a   = (i % 5 == 0) ? f : 8'($urandom);
            lit = (i % 7 == 0) ? a : 8'($urandom);
            adr = (i % 3 == 0) ? 7'h7F : (i % 3 == 1) ? 7'h00 : 7'($urandom);
            // Last four rounds use the reserved codes, which change nothing
            op  = (i >= 56) ? 3'(i % 4 == 0 ? 0 : 4 + i % 4) : 3'(1 + i % 4);
            d   = 1'($urandom);
            st  = 3'($urandom);
            apb(1'b1, `REG_FILE_ADDR, {25'h0, adr});
            apb(1'b1, `REG_FILE_DATA, {24'h0, f});
            apb(1'b1, `REG_ACC, {24'h0, a});
            apb(1'b1, `REG_STATUS, {29'h0, st});
            apb(1'b1, `REG_COMMAND, {8'h00, lit, 1'b0, adr, 4'h0, d, op});
            case (op)
                3'h1: r = f - a;
                3'h2: r = a ^ f;
                3'h3: r = {f[3:0], f[7:4]};
                3'h4: r = a ^ lit;
                default: r = a;
            endcase
            if (op == 3'h1) st[1:0] = {a[3:0] <= f[3:0], a <= f};
            if (op == 3'h1 || op == 3'h2 || op == 3'h4) st[2] = (r == 8'h00);
            if (op == 3'h4 || (op != 3'h0 && op < 3'h4 && !d)) a = r;
            else if (op != 3'h0 && op < 3'h4) f = r;
            rd(`REG_ACC, {25'h0, a});
            rd(`REG_STATUS, {30'h0, st});
            rd(`REG_FILE_DATA, {25'h0, f});
        end
        repeat (2) @(posedge i_clk);
        finish_test;
    end
endmodule // tb
`default_nettype wire
